// file: verif/host_pacer.sv
`default_nettype none
module host_pacer (
    input wire logic pclk,
    input wire logic panel_sync_out,
    output int frames
);
    timeunit 1ns; timeprecision 1ps;
    logic last = 1'b0;
    initial frames = 0;
    // host starts a frame write only on a rising sync edge, staying behind the scan
    always @(posedge pclk) begin
        if (panel_sync_out && !last) frames <= frames + 1;
        last <= panel_sync_out;
    end
endmodule
`default_nettype wire

// file: verif/panel_sync_asserts.sv
`default_nettype none
module panel_sync_asserts #(
    parameter int HDL_CYCLES = 2,
    parameter int HDH_CYCLES = 3
) (
    // apb side
    input wire logic pclk, presetn, psel, penable, pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata, prdata,
    // responses and pins
    input wire logic pslverr, panel_sync_out, irq
);
    timeunit 1ns; timeprecision 1ps;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // any ctrl or command write may legally cut a pulse short, so it excuses every run that ends up to the next rise of the pin
    wire logic wr = psel && penable && pwrite;
    wire logic cmd = wr && paddr == 12'h014;
    wire logic kill = cmd || (wr && paddr == 12'h000);
    logic seen_on, asleep, killed, mask_off;
    int lo_run, hi_run;
    // shadow settings and run lengths of the pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {seen_on, asleep, killed, mask_off} <= 4'h1;
            lo_run <= 0;
            hi_run <= 0;
        end else begin
            if (cmd && pwdata[15:8] == 8'h35) seen_on <= 1'b1;
            if (wr && paddr == 12'h000) asleep <= pwdata[0];
            if (wr && paddr == 12'h010) mask_off <= pwdata[1:0] == 2'h0;
            killed <= kill || (killed && !(panel_sync_out && lo_run > 0));
            lo_run <= panel_sync_out ? 0 : lo_run + 1;
            hi_run <= panel_sync_out ? hi_run + 1 : 0;
        end
    end
    a_reset_low:
        assert property ($rose(presetn) |-> !panel_sync_out && !irq) else $error("reset");
    a_quiet_before_on:
        assert property (!seen_on |-> !panel_sync_out) else $error("early");
    a_off_drops:
        assert property (cmd && pwdata[15:8] == 8'h34 |-> ##2 !panel_sync_out) else $error("off");
    a_sleep_low:
        assert property (asleep && $past(asleep) |-> !panel_sync_out) else $error("sleep");
    a_low_min:
        assert property ($rose(panel_sync_out) && !killed |-> lo_run >= HDL_CYCLES) else $error("low");
    a_high_min:
        assert property ($fell(panel_sync_out) && !killed |-> hi_run >= HDH_CYCLES) else $error("high");
    a_unmapped_err:
        assert property (psel && penable && paddr > 12'h014 |-> pslverr && (pwrite || prdata == 0))
            else $error("err");
    a_irq_masked:
        assert property (mask_off && $past(mask_off) |-> !irq) else $error("irq");
    cover property ($rose(panel_sync_out));
    cover property ($rose(irq));
    cover property (psel && penable && pslverr);
endmodule
`default_nettype wire

// file: verif/panel_sync_tear_output_tb.sv
`default_nettype none
module panel_sync_tear_output_tb;
    timeunit 1ns; timeprecision 1ps;
    localparam int LN = 4, VDH = 8, HDL = 2, HDH = 3, VDL = 10;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, r;
    logic [15:0] lfsr = 16'h0017;
    logic pready, pslverr, panel_sync_out, irq;
    int bad_count = 0, checks = 0, frames, n;
    initial forever #2.5 pclk = ~pclk;
    panel_sync_tear_output #(.LINES(LN), .VDH_CYCLES(VDH), .HDL_CYCLES(HDL), .HDH_CYCLES(HDH),
        .VDL_CYCLES(VDL)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb(4'hf), .prdata, .pready, .pslverr, .panel_sync_out, .irq);
    host_pacer host (.pclk, .panel_sync_out, .frames);
    task automatic test_done;
        if (bad_count == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic fail;
        bad_count++;
        test_done;
    endtask
    function automatic logic [15:0] rnd;
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr;
    endfunction
    // entered and left just after a rising edge; one idle cycle follows each transfer
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk) penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            if (++k > 20) fail;
            @(posedge pclk);
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0000_0000);
        cmp(r, x);
    endtask
    task automatic low(input int c);
        repeat (c) begin
            @(posedge pclk);
            cmp(panel_sync_out, 1'b0);
        end
    endtask
    // waits for one full vertical high run, then counts rises and shortest runs up to the next one;
    // a partial run seen on entry is never counted, so the field is always a whole one
    task automatic meas(input int mode);
        int h, l, ris, mh, ml, st;
        {n, h, l, ris, mh, ml, st} = {32'd0, 32'd0, 32'd0, 32'd0, 32'd99, 32'd99, 32'd0};
        do begin
            @(posedge pclk);
            if (++n > 2000) fail;
            if (panel_sync_out) begin
                if (h == 0 && l > 0 && st != 0) ris++;
                if (h == 0 && l > 0 && st != 0 && l < ml) ml = l;
                h++;
                l = 0;
                if (h == VDH && st == 0) st = 1;
            end else begin
                if (h > 0 && h < mh && st != 0) mh = h;
                h = 0;
                l++;
            end
        end while (st == 0 || h != VDH || ris == 0);
        cmp(ris, mode ? LN : 1);
        cmp(ml >= (mode ? HDL : VDL), 1'b1);
        cmp(mh >= (mode ? HDH : VDH), 1'b1);
    endtask
    initial begin
        logic [15:0] v;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        low(30);
        for (int i = 0; i < 5; i++) rd(12'(4 * i), i == 2 ? 32'h0000_0002 : 32'h0000_0000);
        rd(12'h01c, 32'h0000_0000);
        cmp(e, 1'b1);
        for (int i = 0; i < 3; i++) begin
            v = rnd();
            apb(1'b1, 12'h014, {7'h00, v[8:0], 16'h4400});
            rd(12'h004, {23'h0, v[8:0]});
        end
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, 12'h000, {30'h0, m[1], 1'b0});
            apb(1'b1, 12'h014, {16'h0, 8'h35, 7'h0, m[0]});
            rd(12'h000, {28'h0, m[0], 1'b1, m[1], 1'b0});
            meas(m[0]);
        end
        apb(1'b1, 12'h010, 32'h0000_0001);
        n = 0;
        while (irq !== 1'b1) begin
            @(posedge pclk);
            if (++n > 200) fail;
        end
        apb(1'b0, 12'h00c, 32'h0000_0000);
        cmp(r[0], 1'b1);
        apb(1'b1, 12'h010, 32'h0000_0000);
        @(posedge pclk);
        cmp(irq, 1'b0);
        apb(1'b1, 12'h014, 32'h0000_3400);
        low(60);
        apb(1'b1, 12'h00c, 32'h0000_0003);
        rd(12'h00c, 32'h0000_0000);
        apb(1'b1, 12'h014, 32'h0000_3501);
        apb(1'b1, 12'h000, 32'h0000_0001);
        low(60);
        apb(1'b1, 12'h000, 32'h0000_0000);
        meas(1);
        cmp(frames > 5, 1'b1);
        test_done;
    end
endmodule
bind panel_sync_tear_output panel_sync_asserts #(.HDL_CYCLES(HDL_CYCLES), .HDH_CYCLES(HDH_CYCLES)) chk (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pslverr, .panel_sync_out, .irq);
`default_nettype wire

// file: verilog/panel_sync_defines.svh
`ifndef PANEL_SYNC_DEFINES_SVH
`define PANEL_SYNC_DEFINES_SVH

// apb register byte offsets
`define REG_CTRL 12'h000
`define REG_SCANLINE 12'h004
`define REG_STATUS 12'h008
`define REG_IRQ_STATUS 12'h00C
`define REG_IRQ_MASK 12'h010
`define REG_COMMAND 12'h014

// command codes written to the command register
`define CMD_TEAR_OFF 8'h34
`define CMD_TEAR_ON 8'h35
`define CMD_TEAR_SCANLINE 8'h44

// control register fields
`define CTRL_SLEEP_BIT 0
`define CTRL_REFRESH_ORDER_BIT 1

// status fields and irq event bits
`define EVT_FIELD_START 0
`define EVT_SCANLINE_HIT 1
`define EVT_WIDTH 2

// timing figures as printed, in picoseconds, and the clock period
`define CLK_PERIOD_PS 5000
`define VDL_MIN_PS 64'd16_500_000_000
`define VDH_MIN_PS 64'd302_000_000
`define HDL_MIN_PS 64'd11_200_000
`define HDH_MIN_PS 64'd22_400_000

// default line count and reset values
`define LINES_PER_FIELD 480
`define SCANLINE_RESET 16'h0000

`endif

// file: verilog/panel_sync_pkg.sv
`default_nettype none
package panel_sync_pkg;
    typedef enum logic [3:0] {
        ST_OFF = 4'b0001,
        ST_VBLANK = 4'b0010,
        ST_LINE_LO = 4'b0100,
        ST_LINE_HI = 4'b1000
    } sync_state_t;

    typedef struct packed {
        logic tear_output_on;
        logic tear_line_output_mode;
        logic sleep_in;
        logic vertical_refresh_order_bit;
        logic [15:0] scanline;
    } sync_cfg_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic [1:0] irq_status;
        logic [1:0] irq_mask;
    } bus_regs_t;
endpackage
`default_nettype wire

// file: verilog/panel_sync_tear_output.sv
// Added by the designer: the address map and the APB slave port.
`include "panel_sync_defines.svh"
`default_nettype none

//Contract
//- output driven only after tear-on; off holds low
//- mode from tear-on and scanline parameters; the code takes the mode from the tear-on parameter only
//- mode-0: high when idle, low while scanning
//- mode-1: one vertical plus 480 line pulses; the code gives LINES-1 line pulses, 479 at the default
//- sleep-in forces output low always
//- vertical low >=16.5ms, high >=302us
//- line low >=11.2us, high >=22.4us
//- timing independent of refresh-order bit
module panel_sync_tear_output
    import panel_sync_pkg::*;
#(
    parameter int LINES = `LINES_PER_FIELD,
    parameter int VDH_CYCLES = int'((`VDH_MIN_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS),
    parameter int HDL_CYCLES = int'((`HDL_MIN_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS),
    parameter int HDH_CYCLES = int'((`HDH_MIN_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS),
    parameter int VDL_CYCLES = int'((`VDL_MIN_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // panel sync pin and interrupt
    output logic panel_sync_out,
    output logic irq
);
    // scanning low interval is the larger of 479 line periods plus one line low time and the vertical low minimum
    localparam int LINE_PERIOD = HDL_CYCLES + HDH_CYCLES;
    localparam int CW = 32;

    typedef struct packed {
        sync_state_t state;
        logic [CW-1:0] cnt;
        logic [CW-1:0] scan_cnt;
        logic [15:0] line;
        logic out;
        sync_cfg_t cfg;
        bus_regs_t regs;
    } state_t;

    state_t cur;
    state_t nxt;

    logic access;
    logic wr;
    logic [`EVT_WIDTH-1:0] evt;
    logic [31:0] rdata;

    assign access = psel && penable;
    assign wr = access && pwrite;

    // read mux; unmapped offsets read zero and flag an error
    always_comb begin
        rdata = 32'h0000_0000;
        pslverr = 1'b0;
        case (paddr)
            `REG_CTRL: rdata = {28'h000_0000, cur.cfg.tear_line_output_mode, cur.cfg.tear_output_on,
                               cur.cfg.vertical_refresh_order_bit, cur.cfg.sleep_in};
            `REG_SCANLINE: rdata = {16'h0000, cur.cfg.scanline};
            `REG_STATUS: rdata = {cur.line, 11'h000, cur.state, cur.out};
            `REG_IRQ_STATUS: rdata = {30'h0000_0000, cur.regs.irq_status};
            `REG_IRQ_MASK: rdata = {30'h0000_0000, cur.regs.irq_mask};
            `REG_COMMAND: rdata = 32'h0000_0000;
            default: pslverr = access;
        endcase
    end

    // next-state logic: command decode, timing generator, irq bookkeeping
    always_comb begin
        nxt = cur;
        evt = '0;
        // scanning counter runs in every state and saturates at all ones, so vertical low reaches its minimum
        if (cur.scan_cnt != '1) begin
            nxt.scan_cnt = cur.scan_cnt + 1'b1;
        end
        // register writes
        if (wr && pstrb[0]) begin
            case (paddr)
                `REG_CTRL: begin
                    nxt.cfg.sleep_in = pwdata[`CTRL_SLEEP_BIT];
                    nxt.cfg.vertical_refresh_order_bit = pwdata[`CTRL_REFRESH_ORDER_BIT];
                end
                `REG_COMMAND: begin
                    case (pwdata[15:8])
                        `CMD_TEAR_OFF: nxt.cfg.tear_output_on = 1'b0;
                        `CMD_TEAR_ON: begin
                            nxt.cfg.tear_output_on = 1'b1;
                            nxt.cfg.tear_line_output_mode = pwdata[0];
                        end
                        `CMD_TEAR_SCANLINE: nxt.cfg.scanline = {7'h00, pwdata[24:16]};
                        default: ;
                    endcase
                end
                `REG_IRQ_MASK: nxt.regs.irq_mask = pwdata[`EVT_WIDTH-1:0];
                default: ;
            endcase
        end
        if (wr && pstrb[1] && paddr == `REG_SCANLINE) begin
            nxt.cfg.scanline = pwdata[15:0];
        end
        // timing generator; the refresh-order bit is not read, so both settings share timing
        nxt.cnt = cur.cnt + 1'b1;
        case (cur.state)
            ST_OFF: begin
                nxt.out = 1'b0;
                nxt.cnt = '0;
                if (cur.cfg.tear_output_on && !cur.cfg.sleep_in) begin
                    nxt.state = ST_VBLANK;
                end
            end
            ST_VBLANK: begin
                nxt.out = 1'b1;
                if (cur.cnt >= CW'(VDH_CYCLES - 1)) begin
                    nxt.state = ST_LINE_LO;
                    nxt.cnt = '0;
                    nxt.scan_cnt = '0;
                    nxt.line = '0;
                    evt[`EVT_FIELD_START] = 1'b1;
                end
            end
            ST_LINE_LO: begin
                nxt.out = 1'b0;
                if (cur.cnt >= CW'(HDL_CYCLES - 1)) begin
                    nxt.cnt = '0;
                    if (cur.line == 16'(LINES - 1)) begin
                        // last line stays low until the vertical low minimum is met
                        if (cur.scan_cnt >= CW'(VDL_CYCLES - 1)) begin
                            nxt.state = ST_VBLANK;
                        end else begin
                            nxt.cnt = cur.cnt;
                        end
                    end else begin
                        nxt.state = ST_LINE_HI;
                    end
                end
            end
            ST_LINE_HI: begin
                // in mode 1 the line gap shows as a high pulse, in mode 0 the pin stays low
                nxt.out = cur.cfg.tear_line_output_mode;
                if (cur.cnt >= CW'(HDH_CYCLES - 1)) begin
                    nxt.cnt = '0;
                    nxt.line = cur.line + 1'b1;
                    nxt.state = ST_LINE_LO;
                    if (cur.line + 1'b1 == cur.cfg.scanline) begin
                        evt[`EVT_SCANLINE_HIT] = 1'b1;
                    end
                end
            end
            default: nxt.state = ST_OFF;
        endcase
        // disable or sleep drops the pin at once, regardless of mode
        if (!nxt.cfg.tear_output_on || nxt.cfg.sleep_in) begin
            nxt.state = ST_OFF;
            nxt.out = 1'b0;
        end
        // sticky irq flags; a new event wins over a write-one clear
        if (wr && pstrb[0] && paddr == `REG_IRQ_STATUS) begin
            nxt.regs.irq_status = cur.regs.irq_status & ~pwdata[`EVT_WIDTH-1:0];
        end
        nxt.regs.irq_status = nxt.regs.irq_status | evt;
        nxt.regs.prdata = (access && !pwrite) ? rdata : cur.regs.prdata;
    end

    // single state register; reset leaves the output off and low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur <= '{state: ST_OFF, cnt: '0, scan_cnt: '0, line: '0, out: 1'b0,
                     cfg: '{tear_output_on: 1'b0, tear_line_output_mode: 1'b0, sleep_in: 1'b0,
                            vertical_refresh_order_bit: 1'b0, scanline: `SCANLINE_RESET},
                     regs: '{prdata: 32'h0000_0000, irq_status: 2'b00, irq_mask: 2'b00}};
        end else begin
            cur <= nxt;
        end
    end

    // zero-wait slave: read data muxed live in the access phase
    assign pready = 1'b1;
    assign prdata = rdata;
    assign panel_sync_out = cur.out; // host paces frame writes on this
    assign irq = |(cur.regs.irq_status & cur.regs.irq_mask);
endmodule
`default_nettype wire
